// *** bench/asd_target_model.sv ***
// target model: rom/ram and peripheral registers answering in the same cycle
`timescale 1ns/1ps
module asd_target_model
    import asd_pkg::*;
(
    input wire logic mclk,
    input wire logic mem_req,
    input wire logic [25:0] mem_addr,
    output logic [31:0] mem_rdata,
    input wire logic peri_req,
    input wire logic peri_we,
    input wire logic [11:0] peri_addr,
    input wire logic [15:0] peri_wdata,
    output logic [15:0] peri_rdata,
    output logic peri_defined
);
    logic [11:0] log_addr [16];
    logic [15:0] log_data [16];
    int log_n = 0;
    logic flip = 1'b0;
    always @(posedge mclk) flip <= ~flip;
    // idle buses toggle so that a stale capture cannot pass for a real read
    assign mem_rdata = mem_req ? {6'h15, mem_addr} : {32{flip}};
    assign peri_rdata = peri_req ? {4'h0, peri_addr} : {16{flip}};
    // offsets from 800 upward hold no register
    assign peri_defined = ~peri_addr[11];
    always @(posedge mclk) begin
        if (peri_req && peri_we) begin
            log_addr[log_n[3:0]] <= peri_addr;
            log_data[log_n[3:0]] <= peri_wdata;
            log_n <= log_n + 1;
        end
    end
endmodule

// *** bench/tb_top.sv ***
// testbench for the cpu address space decoder
`timescale 1ns/1ps
module tb_top
    import asd_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic fetch_req = 1'b0, op_req = 1'b0, zr = 1'b0, op_we = 1'b0, byte_reg = 1'b0;
    logic [31:0] fetch_pc = 32'h0, op_base = 32'h0, op_wdata = 32'h0;
    logic [15:0] disp = 16'h0;
    logic [1:0] op_size = 2'h0;
    logic fetch_gnt, fetch_fault, op_gnt, op_done, op_fault, mem_req, peri_req, peri_we, peri_def;
    logic [25:0] fetch_phys, mem_addr;
    asd_tgt_e fetch_tgt, mem_tgt;
    logic [31:0] op_rdata, op_vaddr, mem_rdata;
    logic [11:0] peri_addr;
    logic [15:0] peri_wdata, peri_rdata;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    always #5 mclk = ~mclk;
    // small rom and ram so that both prohibited ranges are reachable
    asd_decoder #(.ROM_KB(16), .RAM_KB(8)) u_dut (.mclk(mclk), .rstn(rstn),
        .fetch_req(fetch_req), .fetch_pc(fetch_pc), .fetch_gnt(fetch_gnt),
        .fetch_phys(fetch_phys), .fetch_tgt(fetch_tgt), .fetch_fault(fetch_fault),
        .op_req(op_req), .op_base(op_base), .op_base_is_zero_register(zr),
        .signed_16bit_displacement(disp), .op_we(op_we), .op_size(op_size),
        .op_wdata(op_wdata), .peri_byte_reg(byte_reg), .op_gnt(op_gnt), .op_done(op_done),
        .op_rdata(op_rdata), .op_vaddr(op_vaddr), .op_fault(op_fault), .mem_req(mem_req),
        .mem_tgt(mem_tgt), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .peri_req(peri_req),
        .peri_we(peri_we), .peri_addr(peri_addr), .peri_wdata(peri_wdata),
        .peri_rdata(peri_rdata), .peri_defined(peri_def));
    asd_target_model u_tgt (.mclk(mclk), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .peri_req(peri_req), .peri_we(peri_we), .peri_addr(peri_addr),
        .peri_wdata(peri_wdata), .peri_rdata(peri_rdata), .peri_defined(peri_def));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // the whole run needs under a hundred cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic fetch(input logic [31:0] pc, input logic [25:0] ph, input asd_tgt_e t,
                         input logic f);
        logic g;
        logic mr;
        asd_tgt_e mt;
        @(posedge mclk);
        #1;
        fetch_pc = pc;
        fetch_req = 1'b1;
        g = 1'b0;
        mr = 1'b0;
        mt = ASD_TGT_NONE;
        while (g !== 1'b1) begin
            @(negedge mclk);
            g = fetch_gnt;
            mr = mem_req;
            mt = mem_tgt;
            @(posedge mclk);
        end
        #1;
        fetch_req = 1'b0;
        check("mem_req", {31'h0, mr}, {31'h0, (t != ASD_TGT_NONE)});
        check("mem_tgt", {30'h0, mt}, {30'h0, t});
        check("fetch_phys", {6'h0, fetch_phys}, {6'h0, ph});
        check("fetch_tgt", {30'h0, fetch_tgt}, {30'h0, t});
        check("fetch_fault", {31'h0, fetch_fault}, {31'h0, f});
    endtask
    task automatic op(input logic [31:0] b, input logic [15:0] d, input logic z,
                      input logic we, input logic [1:0] sz, input logic [31:0] wd);
        logic g;
        int i;
        @(posedge mclk);
        #1;
        op_base = b;
        disp = d;
        zr = z;
        op_we = we;
        op_size = sz;
        op_wdata = wd;
        op_req = 1'b1;
        g = 1'b0;
        while (g !== 1'b1) begin
            @(negedge mclk);
            g = op_gnt;
            @(posedge mclk);
        end
        #1;
        op_req = 1'b0;
        for (i = 0; i < 8 && op_done !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        check("op_done", {31'h0, op_done}, 32'h1);
    endtask
    task automatic chk_op(input logic [31:0] rd, input logic [31:0] va, input logic f,
                          input logic [31:0] m);
        check("op_rdata", op_rdata & m, rd);
        check("op_vaddr", op_vaddr, va);
        check("op_fault", {31'h0, op_fault}, {31'h0, f});
    endtask
    task automatic t_fetch();
        fetch(32'hfc000100, 26'h0000100, ASD_TGT_ROM, 1'b0);
        fetch(32'h00003ffc, 26'h0003ffc, ASD_TGT_ROM, 1'b0);
        fetch(32'h00100000, 26'h0100000, ASD_TGT_NONE, 1'b1);
        fetch(32'h03ffeffc, 26'h3ffeffc, ASD_TGT_RAM, 1'b0);
        fetch(32'h03fff000, 26'h3fff000, ASD_TGT_NONE, 1'b1);
    endtask
    task automatic t_mem();
        op(32'hfc003ff0, 16'h000c, 1'b0, 1'b0, SZ_WORD, 32'h0);
        chk_op(32'h54003ffc, 32'h00003ffc, 1'b0, 32'hffffffff);
        op(32'h00000000, 16'h4000, 1'b0, 1'b0, SZ_WORD, 32'h0);
        chk_op(32'h0, 32'h00004000, 1'b1, 32'hffffffff);
        op(32'hfffffff0, 16'h0020, 1'b0, 1'b0, SZ_WORD, 32'h0);
        chk_op(32'h54000010, 32'h00000010, 1'b0, 32'hffffffff);
        op(32'hffffd000, 16'h0000, 1'b0, 1'b0, SZ_WORD, 32'h0);
        chk_op(32'h57ffd000, 32'hffffd000, 1'b0, 32'hffffffff);
        op(32'h03ffcffc, 16'h0000, 1'b0, 1'b0, SZ_WORD, 32'h0);
        chk_op(32'h0, 32'hffffcffc, 1'b1, 32'hffffffff);
        op(32'h03ffeffc, 16'h0000, 1'b0, 1'b0, SZ_WORD, 32'h0);
        chk_op(32'h57ffeffc, 32'hffffeffc, 1'b0, 32'hffffffff);
    endtask
    task automatic t_peri();
        op(32'h12345678, 16'hf010, 1'b1, 1'b0, SZ_HALF, 32'h0);
        chk_op(32'h00000010, 32'hfffff010, 1'b0, 32'h0000ffff);
        op(32'h03fff023, 16'h0000, 1'b0, 1'b0, SZ_WORD, 32'h0);
        chk_op(32'h00220020, 32'hfffff023, 1'b0, 32'hffffffff);
        n = u_tgt.log_n;
        op(32'h03fff023, 16'h0000, 1'b0, 1'b1, SZ_WORD, 32'h1234abcd);
        check("lo addr", {20'h0, u_tgt.log_addr[n[3:0]]}, 32'h020);
        check("lo data", {16'h0, u_tgt.log_data[n[3:0]]}, 32'habcd);
        check("hi addr", {20'h0, u_tgt.log_addr[n[3:0] + 4'h1]}, 32'h022);
        check("hi data", {16'h0, u_tgt.log_data[n[3:0] + 4'h1]}, 32'h1234);
        byte_reg = 1'b1;
        op(32'hfffff030, 16'h0000, 1'b0, 1'b1, SZ_HALF, 32'h0000abcd);
        check("byte data", {16'h0, u_tgt.log_data[n[3:0] + 4'h2]}, 32'h00cd);
        op(32'hfffff030, 16'h0000, 1'b0, 1'b0, SZ_HALF, 32'h0);
        chk_op(32'h30, 32'hfffff030, 1'b0, 32'h000000ff);
        op(32'hfffff034, 16'h0000, 1'b0, 1'b1, SZ_BYTE, 32'h000012ef);
        check("byte addr", {20'h0, u_tgt.log_addr[n[3:0] + 4'h3]}, 32'h034);
        check("byte low", {16'h0, u_tgt.log_data[n[3:0] + 4'h3] & 16'h00ff}, 32'h00ef);
        byte_reg = 1'b0;
        op(32'hfffff900, 16'h0000, 1'b0, 1'b1, SZ_HALF, 32'h5555);
        check("no write", u_tgt.log_n, n + 4);
        op(32'hfffff900, 16'h0000, 1'b0, 1'b0, SZ_HALF, 32'h0);
        chk_op(32'h0, 32'hfffff900, 1'b1, 32'hffffffff);
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        #1;
        rstn = 1'b1;
        t_fetch();
        t_mem();
        t_peri();
        conclude();
    end
endmodule

// *** src/asd_decoder.sv ***
// cpu address space decoder: fetch path onto rom and ram, operand path onto rom, ram and peripherals
`timescale 1ns/1ps
module asd_decoder
    import asd_pkg::*;
#(
    parameter int ROM_KB = ROM_KB_DEFAULT,
    parameter int RAM_KB = RAM_KB_DEFAULT
) (
    input wire logic mclk,
    input wire logic rstn,
    // instruction fetch side
    input wire logic fetch_req,
    input wire logic [31:0] fetch_pc,
    output logic fetch_gnt,
    output logic [25:0] fetch_phys,
    output asd_tgt_e fetch_tgt,
    output logic fetch_fault,
    // operand side
    input wire logic op_req,
    input wire logic [31:0] op_base,
    input wire logic op_base_is_zero_register,
    input wire logic [15:0] signed_16bit_displacement,
    input wire logic op_we,
    input wire logic [1:0] op_size,
    input wire logic [31:0] op_wdata,
    input wire logic peri_byte_reg,
    output logic op_gnt,
    output logic op_done,
    output logic [31:0] op_rdata,
    output logic [31:0] op_vaddr,
    output logic op_fault,
    // rom/ram target port
    output logic mem_req,
    output asd_tgt_e mem_tgt,
    output logic [25:0] mem_addr,
    input wire logic [31:0] mem_rdata,
    // peripheral halfword port
    output logic peri_req,
    output logic peri_we,
    output logic [11:0] peri_addr,
    output logic [15:0] peri_wdata,
    input wire logic [15:0] peri_rdata,
    input wire logic peri_defined
);

    localparam logic [25:0] ROM_TOP = (ROM_KB == 16) ? ROM_TOP_16K :
        (ROM_KB == 32) ? ROM_TOP_32K : (ROM_KB == 64) ? ROM_TOP_64K :
        (ROM_KB == 128) ? ROM_TOP_128K : ROM_TOP_256K;
    localparam logic [25:0] RAM_BASE = (RAM_KB == 8) ? RAM_BASE_8K : RAM_BASE_16K;

    // region classification, shared by both paths
    function automatic asd_tgt_e classify(input logic [25:0] pa);
        if (pa <= ROM_TOP) begin
            return ASD_TGT_ROM;
        end else if (pa >= RAM_BASE && pa <= RAM_WIN_TOP) begin
            return ASD_TGT_RAM;
        end else if (pa >= PERI_BASE) begin
            return ASD_TGT_PERI;
        end
        return ASD_TGT_NONE;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // fetch path

    wire logic [25:0] pc_phys = fetch_pc[25:0];
    wire asd_tgt_e pc_tgt = classify(pc_phys);
    // a fetch that would land in the peripheral window is dropped, so a
    // prefetch running past the ram top makes no access there
    wire logic pc_is_peri = (pc_tgt == ASD_TGT_PERI);
    wire logic pc_ok = (pc_tgt == ASD_TGT_ROM) || (pc_tgt == ASD_TGT_RAM);

    ////////////////////////////////////////////////////////////////////////
    // operand path

    wire logic [31:0] disp_ext = {{16{signed_16bit_displacement[15]}},
        signed_16bit_displacement};
    wire logic [31:0] base_eff = op_base_is_zero_register ? 32'h00000000 : op_base;
    wire logic [31:0] op_sum = base_eff + disp_ext;
    wire logic [25:0] op_phys = op_sum[25:0];
    wire logic [31:0] op_view = {{6{op_phys[25]}}, op_phys};
    wire asd_tgt_e op_tgt = classify(op_phys);

    typedef enum logic [1:0] {
        ASD_IDLE,
        ASD_PERI_LO,
        ASD_PERI_HI
    } asd_state_e;

    asd_state_e state_q, state_d;
    logic [25:0] pa_q;
    logic [31:0] wdata_q;
    logic we_q, word_q, byte_q;
    logic [15:0] lo_q;

    wire logic idle = (state_q == ASD_IDLE);
    wire logic op_start = idle && op_req;
    wire logic op_to_peri = (op_tgt == ASD_TGT_PERI);
    wire logic in_peri = !idle;
    wire logic peri_hi = (state_q == ASD_PERI_HI);

    // fetch has the shared rom/ram port only when no operand uses it
    wire logic op_mem = op_start && (op_tgt == ASD_TGT_ROM || op_tgt == ASD_TGT_RAM);
    assign op_gnt = op_start;
    assign fetch_gnt = fetch_req && !op_mem;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ASD_IDLE: begin
                if (op_start && op_to_peri) begin
                    state_d = ASD_PERI_LO;
                end
            end
            ASD_PERI_LO: begin
                state_d = word_q ? ASD_PERI_HI : ASD_IDLE;
            end
            ASD_PERI_HI: begin
                state_d = ASD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ASD_IDLE;
            pa_q <= 26'h0000000;
            wdata_q <= 32'h00000000;
            we_q <= 1'b0;
            word_q <= 1'b0;
            byte_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (op_start) begin
                pa_q <= op_phys;
                wdata_q <= op_wdata;
                we_q <= op_we;
                word_q <= (op_size == SZ_WORD);
                byte_q <= peri_byte_reg && (op_size != SZ_BYTE);
            end
        end
    end

    // word accesses drop address bits 1..0 and the high half steps by two; halfword keeps its address
    wire logic [11:0] peri_off = word_q ? {pa_q[11:2], peri_hi, 1'b0} : pa_q[11:0];
    wire logic [15:0] peri_wd = peri_hi ? wdata_q[31:16] : wdata_q[15:0];
    // byte register: upper write byte discarded except on byte-size writes, read upper byte meaningless
    wire logic [15:0] peri_wd_eff = byte_q ? {8'h00, peri_wd[7:0]} : peri_wd;
    wire logic peri_rd_fault = in_peri && !peri_defined;
    wire logic [15:0] peri_rd_eff = peri_rd_fault ? 16'h0000 : peri_rdata;

    assign peri_req = in_peri && peri_defined;
    assign peri_we = we_q && peri_defined;
    assign peri_addr = peri_off;
    assign peri_wdata = peri_wd_eff;

    assign mem_req = op_mem || (fetch_gnt && pc_ok);
    assign mem_tgt = op_mem ? op_tgt : (fetch_gnt && pc_ok ? pc_tgt : ASD_TGT_NONE);
    assign mem_addr = op_mem ? op_phys : pc_phys;

    ////////////////////////////////////////////////////////////////////////
    // registered answers

    logic done_q, fault_q, ffault_q;
    logic [31:0] rdata_q, vaddr_q;
    logic [25:0] fphys_q;
    asd_tgt_e ftgt_q;

    wire logic peri_last = in_peri && (peri_hi || !word_q);
    wire logic mem_done = op_mem;
    wire logic none_done = op_start && (op_tgt == ASD_TGT_NONE);
    wire logic [31:0] peri_word = word_q ? {peri_rd_eff, lo_q} : {16'h0000, peri_rd_eff};

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
            fault_q <= 1'b0;
            rdata_q <= 32'h00000000;
            vaddr_q <= 32'h00000000;
            lo_q <= 16'h0000;
            fphys_q <= 26'h0000000;
            ftgt_q <= ASD_TGT_NONE;
            ffault_q <= 1'b0;
        end else begin
            done_q <= mem_done || none_done || peri_last;
            if (state_q == ASD_PERI_LO) begin
                lo_q <= peri_rd_eff;
            end
            if (op_start) begin
                vaddr_q <= op_view;
                fault_q <= (op_tgt == ASD_TGT_NONE);
                rdata_q <= op_mem ? mem_rdata : 32'h00000000;
            end else if (peri_last) begin
                fault_q <= fault_q || peri_rd_fault;
                rdata_q <= peri_word;
            end else if (in_peri) begin
                fault_q <= fault_q || peri_rd_fault;
            end
            if (fetch_gnt) begin
                fphys_q <= pc_phys;
                ftgt_q <= pc_ok ? pc_tgt : ASD_TGT_NONE;
                ffault_q <= !pc_ok;
            end
        end
    end

    assign op_done = done_q;
    assign op_fault = fault_q;
    assign op_rdata = rdata_q;
    assign op_vaddr = vaddr_q;
    assign fetch_phys = fphys_q;
    assign fetch_tgt = ftgt_q;
    assign fetch_fault = ffault_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    fetch_no_peri_a: assert property (fetch_gnt && pc_is_peri |=>
        fetch_tgt == ASD_TGT_NONE && fetch_fault)
        else $error("fetch served from peripheral window");
    fetch_no_req_a: assert property (mem_req && !op_mem |-> mem_tgt != ASD_TGT_PERI)
        else $error("fetch drove a peripheral target");
    mirror_view_a: assert property (op_start |=>
        op_vaddr == {{6{$past(op_phys[25])}}, $past(op_phys)})
        else $error("cpu view not sign extended");
    zero_base_a: assert property (op_base_is_zero_register |->
        op_sum == disp_ext)
        else $error("zero register base not zero");
    word_split_a: assert property (op_start && op_to_peri && op_size == SZ_WORD |=>
        state_q == ASD_PERI_LO ##1 state_q == ASD_PERI_HI && peri_addr[1] ##1 idle && op_done)
        else $error("word peripheral access not split low then high");
    half_once_a: assert property (op_start && op_to_peri && op_size != SZ_WORD |=>
        state_q == ASD_PERI_LO ##1 idle && op_done)
        else $error("halfword peripheral access wrong length");
    byte_upper_a: assert property (peri_req && byte_q |-> peri_wdata[15:8] == 8'h00)
        else $error("upper byte reached byte register");
    hole_fault_a: assert property (op_start && op_phys > ROM_TOP && op_phys < RAM_BASE |=>
        op_fault && op_done)
        else $error("prohibited access not flagged");
    ram_hit_a: assert property (op_start && op_phys >= RAM_BASE && op_phys <= RAM_WIN_TOP |->
        mem_req && mem_tgt == ASD_TGT_RAM)
        else $error("ram access not routed");
    no_write_fault_a: assert property (in_peri && !peri_defined |-> !peri_we)
        else $error("write to undefined peripheral offset");

    word_cov_c: cover property (op_start && op_to_peri && op_size == SZ_WORD ##2 op_done);
    rom_fetch_c: cover property (fetch_gnt && pc_tgt == ASD_TGT_ROM);
    wrap_cov_c: cover property (op_start && op_base_is_zero_register &&
        signed_16bit_displacement[15]);
    fault_cov_c: cover property (op_done && op_fault);

endmodule

// *** src/asd_pkg.sv ***
// constants for the cpu address space decoder
package asd_pkg;
    localparam int ADDR_W = 32;
    localparam int PHYS_W = 26;
    localparam int DISP_W = 16;
    localparam logic [25:0] ROM_WIN_TOP = 26'h00fffff;
    localparam logic [25:0] RAM_WIN_BASE = 26'h3ff0000;
    localparam logic [25:0] RAM_WIN_TOP = 26'h3ffefff;
    localparam logic [25:0] RAM_BASE_8K = 26'h3ffd000;
    localparam logic [25:0] RAM_BASE_16K = 26'h3ffb000;
    localparam logic [25:0] PERI_BASE = 26'h3fff000;
    localparam logic [25:0] PERI_TOP = 26'h3ffffff;
    localparam logic [25:0] ROM_TOP_16K = 26'h0003fff;
    localparam logic [25:0] ROM_TOP_32K = 26'h0007fff;
    localparam logic [25:0] ROM_TOP_64K = 26'h000ffff;
    localparam logic [25:0] ROM_TOP_128K = 26'h001ffff;
    localparam logic [25:0] ROM_TOP_256K = 26'h003ffff;
    localparam logic [25:0] FETCH_BYTES = 26'h0000004;
    localparam int ROM_KB_DEFAULT = 256;
    localparam int RAM_KB_DEFAULT = 16;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    typedef enum logic [1:0] {
        ASD_TGT_NONE,
        ASD_TGT_ROM,
        ASD_TGT_RAM,
        ASD_TGT_PERI
    } asd_tgt_e;
endpackage
